//--- swe_pkg.sv
// Shared constants and types of the single-wire waveform engine.
package swe_pkg;

  // Timebase: 40 MHz clock, microsecond tick derived from the period.
  localparam int        CLK_PERIOD_NS = 25;
  localparam int        US_NS         = 1000;
  localparam logic [5:0] US_CYCLES    = 6'(US_NS / CLK_PERIOD_NS);

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_SPEED  = 8'h0c;
  localparam logic [7:0] OFS_LOW1   = 8'h10;
  localparam logic [7:0] OFS_DSO    = 8'h14;
  localparam logic [7:0] OFS_REC0   = 8'h18;
  localparam logic [7:0] OFS_SPU    = 8'h1c;
  localparam logic [7:0] OFS_HALT   = 8'h20;

  // Command word fields.
  localparam int CMD_W       = 8;
  localparam int CMD_DEPTH   = 4;
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_BIT_POS = 2;
  localparam int CMD_PST_POS = 3;
  localparam int CMD_NTF_POS = 4;
  localparam int CMD_INH_POS = 5;

  // Response byte fields.
  localparam int RSP_SHORT  = 0;
  localparam int RSP_NOPRES = 1;
  localparam int RSP_ALARM  = 2;
  localparam int RSP_BIT    = 3;
  localparam int RSP_NTF    = 4;

  // Reset values of the software registers.
  localparam logic [1:0]  RST_SPEED = 2'h0;
  localparam logic [15:0] RST_LOW1  = 16'h0008;
  localparam logic [15:0] RST_DSO   = 16'h0007;
  localparam logic [15:0] RST_REC0  = 16'h0012;
  localparam logic [15:0] RST_SPU   = 16'h0200;

  // Segment times in microseconds, standard (regular/flexible) and overdrive.
  localparam logic [15:0] RESET_LOW_TIME_STD           = 16'h0200;
  localparam logic [15:0] RESET_LOW_TIME_OD            = 16'h0040;
  localparam logic [15:0] SHORT_INTR_SAMPLE_OFFSET_STD = 16'h0008;
  localparam logic [15:0] SHORT_INTR_SAMPLE_OFFSET_OD  = 16'h0002;
  localparam logic [15:0] PRESENCE_SAMPLE_OFFSET_STD   = 16'h0040;
  localparam logic [15:0] PRESENCE_SAMPLE_OFFSET_OD    = 16'h0008;
  localparam logic [15:0] POST_SAMPLE_FILL_DELAY_STD   = 16'h0190;
  localparam logic [15:0] POST_SAMPLE_FILL_DELAY_OD    = 16'h0030;
  localparam logic [15:0] WRITE_ONE_LOW_TIME_STD       = 16'h0008;
  localparam logic [15:0] WRITE_ONE_LOW_TIME_OD        = 16'h0001;
  localparam logic [15:0] DATA_SAMPLE_OFFSET_STD       = 16'h000c;
  localparam logic [15:0] DATA_SAMPLE_OFFSET_OD        = 16'h0002;
  localparam logic [15:0] WRITE_ONE_HIGH_TIME_STD      = 16'h0032;
  localparam logic [15:0] WRITE_ONE_HIGH_TIME_OD       = 16'h0007;
  localparam logic [15:0] WRITE_ZERO_LOW_TIME_STD      = 16'h003c;
  localparam logic [15:0] WRITE_ZERO_LOW_TIME_OD       = 16'h0008;
  localparam logic [15:0] WRITE_ZERO_RECOVERY_STD      = 16'h000a;
  localparam logic [15:0] WRITE_ZERO_RECOVERY_OD       = 16'h0002;
  localparam logic [15:0] SHORT_WAIT_US_DEF            = 16'h1000;

  typedef enum logic [1:0] {
    SPD_REGULAR   = 2'b00,
    SPD_FLEXIBLE  = 2'b01,
    SPD_OVERDRIVE = 2'b10
  } swe_speed_type;

  typedef enum logic [1:0] {
    OP_RESET = 2'b00,
    OP_BIT   = 2'b01,
    OP_PULSE = 2'b10
  } swe_op_type;

  typedef enum logic [3:0] {
    SEG_RSTL  = 4'b0000,
    SEG_SI    = 4'b0001,
    SEG_PDT   = 4'b0010,
    SEG_FILL  = 4'b0011,
    SEG_SHORT = 4'b0100,
    SEG_LOW1  = 4'b0101,
    SEG_DSO   = 4'b0110,
    SEG_HIGH1 = 4'b0111,
    SEG_LOW0  = 4'b1000,
    SEG_REC0  = 4'b1001,
    SEG_SPU   = 4'b1010
  } swe_seg_type;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'b0000,
    ST_PREP       = 4'b0001,
    ST_RST_LOW    = 4'b0010,
    ST_SI_WAIT    = 4'b0011,
    ST_PDT_WAIT   = 4'b0100,
    ST_FILL       = 4'b0101,
    ST_SHORT_WAIT = 4'b0110,
    ST_SLOT_LOW   = 4'b0111,
    ST_DSO_WAIT   = 4'b1000,
    ST_HIGH1      = 4'b1001,
    ST_ZERO_LOW   = 4'b1010,
    ST_REC0       = 4'b1011,
    ST_PULSE      = 4'b1100,
    ST_DONE       = 4'b1101
  } swe_state_type;

endpackage

//--- swe_fifo_if.sv
// Valid/ready carrier between the engine and its command FIFO.
`timescale 1ns/1ps
`default_nettype none
interface swe_fifo_if #(parameter int W = 8);
  logic         inValid;
  logic         inReady;
  logic [W-1:0] inData;
  logic         outValid;
  logic         outReady;
  logic [W-1:0] outData;
  modport fifo (input inValid, inData, outReady,
                output inReady, outValid, outData);
  modport user (output inValid, inData, outReady,
                input inReady, outValid, outData);
endinterface
`default_nettype wire

//--- swe_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module swe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  swe_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [AW-1:0]    wrPtrQ;
  logic [AW-1:0]    rdPtrQ;
  logic [CW-1:0]    cntQ;
  wire              push = port.inValid && port.inReady;
  wire              pop  = port.outValid && port.outReady;

  assign port.inReady  = cntQ != CW'(DEPTH);
  assign port.outValid = cntQ != '0;
  assign port.outData  = memQ[rdPtrQ];

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : gStore
      always_ff @(posedge clk) begin
        if (push && wrPtrQ == AW'(i)) begin
          memQ[i] <= port.inData;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      cntQ   <= '0;
    end else begin
      if (push) wrPtrQ <= nextPtr(wrPtrQ);
      if (pop) rdPtrQ <= nextPtr(rdPtrQ);
      cntQ <= cntQ + CW'(push) - CW'(pop);
    end
  end
endmodule
`default_nettype wire

//--- swe_waveform_engine.sv
// Single-wire bus waveform engine with AHB-Lite register slave.
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module swe_waveform_engine #(
  parameter logic [15:0] SHORT_WAIT_US = swe_pkg::SHORT_WAIT_US_DEF
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        busIn,
  output logic             busOut,
  output logic             busOe,
  output logic             weakPuEn,
  output logic             strongPuEn
);
  import swe_pkg::*;
  swe_fifo_if #(.W(CMD_W)) cmdIf ();
  swe_fifo #(.WIDTH(CMD_W), .DEPTH(CMD_DEPTH)) uCmdFifo (
    .clk  (mclk),
    .rst  (reset),
    .port (cmdIf.fifo));

  logic [7:0]     addrQ;
  logic           dphWrQ;
  logic [31:0]    rdataQ;
  swe_speed_type  speedQ;
  logic [15:0]    low1Q;
  logic [15:0]    dsoQ;
  logic [15:0]    rec0Q;
  logic [15:0]    spuQ;
  logic           haltQ;
  swe_state_type  stateQ;
  swe_state_type  stateD;
  logic           loadEn;
  swe_seg_type    loadSeg;
  logic [5:0]     usDivQ;
  logic [15:0]    segCntQ;
  logic [CMD_W-1:0] cmdQ;
  logic           shortQ;
  logic           alarmQ;
  logic           presQ;
  logic           bitQ;
  logic [7:0]     respQ;
  logic           respReadyQ;

  wire apAcc  = hsel && htrans[1] && hready;
  wire rdRes  = apAcc && !hwrite && haddr[7:0] == OFS_RESULT;
  wire dphCmd = dphWrQ && addrQ == OFS_CMD;
  wire wrEn   = dphWrQ && hreadyout;
  wire wrSpd  = wrEn && addrQ == OFS_SPEED;
  wire wrLow1 = wrEn && addrQ == OFS_LOW1;
  wire wrDso  = wrEn && addrQ == OFS_DSO;
  wire wrRec0 = wrEn && addrQ == OFS_REC0;
  wire wrSpu  = wrEn && addrQ == OFS_SPU;
  wire wrHalt = wrEn && addrQ == OFS_HALT;
  // A command write stalls the bus while the FIFO is full.
  assign hreadyout     = !(dphCmd && !cmdIf.inReady);
  assign hresp         = 1'b0;
  assign hrdata        = rdataQ;
  assign cmdIf.inValid = dphCmd;
  assign cmdIf.inData  = hwdata[CMD_W-1:0];

  wire [7:0]  status = {3'b000, !cmdIf.inReady, !cmdIf.outValid,
                        respReadyQ, stateQ != ST_IDLE, busIn};
  wire [7:0]  ra     = haddr[7:0];
  wire [31:0] rdMux  =
    (ra == OFS_CMD)    ? {24'h000000, cmdQ} :
    (ra == OFS_STATUS) ? {24'h000000, status} :
    (ra == OFS_RESULT) ? {24'h000000, respQ} :
    (ra == OFS_SPEED)  ? {30'h00000000, speedQ} :
    (ra == OFS_LOW1)   ? {16'h0000, low1Q} :
    (ra == OFS_DSO)    ? {16'h0000, dsoQ} :
    (ra == OFS_REC0)   ? {16'h0000, rec0Q} :
    (ra == OFS_SPU)    ? {16'h0000, spuQ} : 32'h00000000;
  always_ff @(posedge mclk) begin
    if (reset) begin
      addrQ  <= 8'h00;
      dphWrQ <= 1'b0;
      rdataQ <= 32'h00000000;
    end else if (hready) begin
      addrQ  <= haddr[7:0];
      dphWrQ <= apAcc && hwrite;
      rdataQ <= (apAcc && !hwrite) ? rdMux : rdataQ;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      speedQ <= swe_speed_type'(RST_SPEED);
      low1Q  <= RST_LOW1;
      dsoQ   <= RST_DSO;
      rec0Q  <= RST_REC0;
      spuQ   <= RST_SPU;
      haltQ  <= 1'b0;
    end else begin
      if (wrSpd) speedQ <= swe_speed_type'(hwdata[1:0]);
      if (wrLow1) low1Q <= hwdata[15:0];
      if (wrDso) dsoQ <= hwdata[15:0];
      if (wrRec0) rec0Q <= hwdata[15:0];
      if (wrSpu) spuQ <= hwdata[15:0];
      haltQ <= wrHalt && hwdata[0];
    end
  end

  // Segment length in microseconds for the current speed.
  wire od = speedQ == SPD_OVERDRIVE;
  wire fx = speedQ == SPD_FLEXIBLE;
  function automatic logic [15:0] segTime(input swe_seg_type seg);
    case (seg)
      SEG_RSTL:  segTime = od ? RESET_LOW_TIME_OD : RESET_LOW_TIME_STD;
      SEG_SI:    segTime = od ? SHORT_INTR_SAMPLE_OFFSET_OD
                              : SHORT_INTR_SAMPLE_OFFSET_STD;
      SEG_PDT:   segTime = od ? PRESENCE_SAMPLE_OFFSET_OD
                              : PRESENCE_SAMPLE_OFFSET_STD;
      SEG_FILL:  segTime = od ? POST_SAMPLE_FILL_DELAY_OD
                              : POST_SAMPLE_FILL_DELAY_STD;
      SEG_SHORT: segTime = SHORT_WAIT_US;
      SEG_LOW1:  segTime = od ? WRITE_ONE_LOW_TIME_OD
                              : fx ? low1Q : WRITE_ONE_LOW_TIME_STD;
      SEG_DSO:   segTime = od ? DATA_SAMPLE_OFFSET_OD
                              : fx ? dsoQ : DATA_SAMPLE_OFFSET_STD;
      SEG_HIGH1: segTime = od ? WRITE_ONE_HIGH_TIME_OD
                              : WRITE_ONE_HIGH_TIME_STD;
      SEG_LOW0:  segTime = od ? WRITE_ZERO_LOW_TIME_OD
                              : WRITE_ZERO_LOW_TIME_STD;
      SEG_REC0:  segTime = od ? WRITE_ZERO_RECOVERY_OD
                              : fx ? rec0Q : WRITE_ZERO_RECOVERY_STD;
      SEG_SPU:   segTime = spuQ;
      default:   segTime = 16'h0001;
    endcase
  endfunction

  wire usTick   = usDivQ == US_CYCLES - 6'h01;
  wire segDone  = segCntQ == 16'h0000;
  wire popCmd   = cmdIf.outValid && cmdIf.outReady;
  wire [1:0] op = cmdIf.outData[CMD_OP_LSB +: 2];
  wire cmdBit   = cmdQ[CMD_BIT_POS];
  wire cmdPst   = cmdQ[CMD_PST_POS];
  wire cmdNtf   = cmdQ[CMD_NTF_POS];
  wire cmdInh   = cmdQ[CMD_INH_POS];
  wire isReset  = cmdQ[CMD_OP_LSB +: 2] == OP_RESET;
  wire noPres   = isReset && !shortQ && !alarmQ && !presQ;
  wire spuInf   = spuQ == 16'h0000;

  assign cmdIf.outReady = stateQ == ST_IDLE;
  wire respSet = stateQ == ST_DONE && !cmdInh &&
                 (!isReset || cmdNtf || shortQ || alarmQ || cmdPst && noPres);
  wire [7:0] respByte = {3'b000, cmdNtf, bitQ, alarmQ,
                         cmdPst && noPres, shortQ};

  always_comb begin
    stateD  = stateQ;
    loadEn  = 1'b0;
    loadSeg = SEG_RSTL;
    case (stateQ)
      ST_IDLE: begin
        if (popCmd && op == OP_PULSE) begin
          stateD  = ST_PULSE;
          loadEn  = 1'b1;
          loadSeg = SEG_SPU;
        end else if (popCmd) begin
          stateD = ST_PREP;
        end
      end
      ST_PREP: begin
        loadEn = 1'b1;
        if (isReset) begin
          stateD  = ST_RST_LOW;
          loadSeg = SEG_RSTL;
        end else if (cmdBit) begin
          stateD  = ST_SLOT_LOW;
          loadSeg = SEG_LOW1;
        end else begin
          stateD  = ST_ZERO_LOW;
          loadSeg = SEG_LOW0;
        end
      end
      ST_RST_LOW: if (segDone) begin
        stateD  = ST_SI_WAIT;
        loadEn  = 1'b1;
        loadSeg = SEG_SI;
      end
      ST_SI_WAIT: if (segDone) begin
        loadEn = 1'b1;
        if (busIn) begin
          stateD  = ST_PDT_WAIT;
          loadSeg = SEG_PDT;
        end else begin
          stateD  = ST_SHORT_WAIT;
          loadSeg = SEG_SHORT;
        end
      end
      ST_PDT_WAIT: if (segDone) begin
        stateD  = ST_FILL;
        loadEn  = 1'b1;
        loadSeg = SEG_FILL;
      end
      ST_SHORT_WAIT: if (segDone) begin
        if (busIn) begin
          stateD  = ST_FILL;
          loadEn  = 1'b1;
          loadSeg = SEG_FILL;
        end else begin
          stateD = ST_DONE;
        end
      end
      ST_FILL: if (segDone) stateD = ST_DONE;
      ST_SLOT_LOW: if (segDone) begin
        stateD  = ST_DSO_WAIT;
        loadEn  = 1'b1;
        loadSeg = SEG_DSO;
      end
      ST_DSO_WAIT: if (segDone) begin
        stateD  = ST_HIGH1;
        loadEn  = 1'b1;
        loadSeg = SEG_HIGH1;
      end
      ST_HIGH1: if (segDone) stateD = ST_DONE;
      ST_ZERO_LOW: if (segDone) begin
        stateD  = ST_REC0;
        loadEn  = 1'b1;
        loadSeg = SEG_REC0;
      end
      ST_REC0: if (segDone) stateD = ST_DONE;
      ST_PULSE: begin
        if (haltQ || (!spuInf && segDone)) stateD = ST_DONE;
      end
      ST_DONE: stateD = ST_IDLE;
      default: stateD = ST_IDLE;
    endcase
  end

  // Microsecond prescaler and segment down-counter.
  always_ff @(posedge mclk) begin
    if (reset) begin
      usDivQ  <= 6'h00;
      segCntQ <= 16'h0000;
    end else if (loadEn) begin
      usDivQ  <= 6'h00;
      segCntQ <= segTime(loadSeg);
    end else begin
      usDivQ  <= usTick ? 6'h00 : usDivQ + 6'h01;
      if (usTick && !segDone) segCntQ <= segCntQ - 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stateQ <= ST_IDLE;
      cmdQ   <= '0;
    end else begin
      stateQ <= stateD;
      if (popCmd) cmdQ <= cmdIf.outData;
    end
  end
  wire siLow   = stateQ == ST_SI_WAIT && segDone && !busIn;
  wire pdtDone = stateQ == ST_PDT_WAIT && segDone;
  wire swDone  = stateQ == ST_SHORT_WAIT && segDone;
  wire dsoDone = stateQ == ST_DSO_WAIT && segDone;
  always_ff @(posedge mclk) begin
    if (reset || popCmd) begin
      shortQ <= 1'b0;
      alarmQ <= 1'b0;
      presQ  <= 1'b0;
      bitQ   <= 1'b0;
    end else begin
      if (pdtDone) presQ <= !busIn;
      if (swDone) shortQ <= !busIn;
      if (swDone) alarmQ <= busIn;
      if (dsoDone) bitQ <= busIn;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      respQ      <= 8'h00;
      respReadyQ <= 1'b0;
    end else begin
      if (respSet) respQ <= respByte;
      respReadyQ <= respSet || (respReadyQ && !rdRes);
    end
  end

  // Open-drain driver: the engine only ever pulls low.
  wire pullLow = stateQ == ST_RST_LOW || stateQ == ST_SLOT_LOW ||
                 stateQ == ST_ZERO_LOW;
  assign busOut     = 1'b0;
  assign busOe      = pullLow;
  assign strongPuEn = stateQ == ST_PULSE;
  assign weakPuEn   = !pullLow && stateQ != ST_PREP &&
                      stateQ != ST_PULSE;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence sReleased;
    !busOe && weakPuEn && !strongPuEn;
  endsequence
  sequence sResetEnd;
    stateQ == ST_RST_LOW && segDone;
  endsequence

  AST_WEAK_OFF_FIRST: assert property (
    $rose(busOe) |-> $past(!weakPuEn))
    else $error("Bus pulled low while weak pullup was on.");
  AST_RESET_RELEASE: assert property (
    sResetEnd |=> sReleased ##0 stateQ == ST_SI_WAIT)
    else $error("Bus not released after reset low time.");
  AST_HIGH_WEAK_ONLY: assert property (
    (stateQ inside {ST_SI_WAIT, ST_PDT_WAIT, ST_SHORT_WAIT}) |-> sReleased)
    else $error("Reset high interval not on weak pullup.");
  AST_SI_TO_PDT: assert property (
    stateQ == ST_SI_WAIT && segDone && busIn |=>
      stateQ == ST_PDT_WAIT && segCntQ == segTime(SEG_PDT))
    else $error("High short sample did not start presence wait.");
  AST_SI_TO_SHORT: assert property (
    siLow |=> stateQ == ST_SHORT_WAIT && segCntQ == SHORT_WAIT_US)
    else $error("Low short sample did not start long wait.");
  AST_SHORT_FLAG: assert property (
    swDone && !busIn |=> stateQ == ST_DONE && shortQ ##1
      (cmdInh || respQ[RSP_SHORT]))
    else $error("Short circuit not reported.");
  AST_ALARM: assert property (
    swDone && busIn |=> stateQ == ST_FILL && alarmQ && !presQ)
    else $error("Alarming presence not flagged.");
  AST_SLOT_SAMPLE: assert property (
    dsoDone |=> bitQ == $past(busIn) && stateQ == ST_HIGH1)
    else $error("Read slot sample not taken at offset.");
  AST_ZERO_REC: assert property (
    stateQ == ST_ZERO_LOW && segDone |=> stateQ == ST_REC0 && !busOe)
    else $error("Write-zero slot lacks recovery.");
  AST_PULSE_HALT: assert property (
    stateQ == ST_PULSE && haltQ |=> !strongPuEn ##1 stateQ == ST_IDLE)
    else $error("Halt did not end the strong pullup.");
  AST_REC0_DEFAULT: assert property (
    $fell(reset) |-> rec0Q == RST_REC0)
    else $error("Recovery default wrong after reset.");
  AST_US_TICK: assert property (
    usTick && !loadEn |=> usDivQ == 6'h00 ##1
      (usDivQ == 6'h01 || $past(loadEn)))
    else $error("Microsecond prescaler out of step.");
endmodule
`default_nettype wire

//--- swe_slave_model.sv
// Behavioural model of the slave devices on the single-wire bus.
`timescale 1ns/1ps
`default_nettype none
module swe_slave_model (
  input  wire logic       mclk,
  input  wire logic       engLow,
  input  wire logic [1:0] mode,
  input  wire logic       readZero,
  output logic            pullLow
);
  logic [15:0] lowCnt  = 16'h0000;
  logic [15:0] relCnt  = 16'hffff;
  logic [15:0] slotCnt = 16'hffff;
  wire         presWin = relCnt >= 16'h0078 && relCnt < 16'h0320;
  always_ff @(posedge mclk) begin
    lowCnt <= engLow ? lowCnt + 16'h0001 : 16'h0000;
    if (engLow && lowCnt == 16'h0000) begin
      slotCnt <= 16'h0000;
    end else if (slotCnt != 16'hffff) begin
      slotCnt <= slotCnt + 16'h0001;
    end
    if (!engLow && lowCnt >= 16'h09b0) begin
      relCnt <= 16'h0000;
    end else if (relCnt != 16'hffff) begin
      relCnt <= relCnt + 16'h0001;
    end
  end
  // Mode 0 presence, 1 nobody, 2 shorted line, 3 alarm pulse.
  assign pullLow = (mode == 2'h2) ||
                   (mode == 2'h0 && presWin) ||
                   (mode == 2'h3 && relCnt < 16'h00a0) ||
                   (readZero && slotCnt < 16'h04b0);
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the single-wire waveform engine.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import swe_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        hreadyout, hresp, busOut, busOe, weakPuEn, strongPuEn;
  logic [31:0] hrdata, rd;
  logic [1:0]  mode = 2'h1;
  logic        readZero = 1'b0;
  logic        pullLow;
  logic [31:0] lowCnt = '0, lowLen = '0, spuCnt = '0, spuLen = '0;
  logic        oePrev = 1'b0, weakPrev = 1'b1;
  int          mismatches = 0;
  int          samples_checked = 0;
  wire         busLine = !((busOe && !busOut) || pullLow);

  always #12.5 mclk = ~mclk;

  swe_waveform_engine #(.SHORT_WAIT_US(16'h0004)) u_dut (
    .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .busIn(busLine), .busOut(busOut), .busOe(busOe),
    .weakPuEn(weakPuEn), .strongPuEn(strongPuEn));
  swe_slave_model u_slave (.mclk(mclk), .engLow(busOe), .mode(mode),
    .readZero(readZero), .pullLow(pullLow));

  task automatic chk(input string what, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] near(input logic [31:0] got, e);
    return (got >= e && got <= e + 2) ? e : got;
  endfunction
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic waitSt(input int b, input logic v);
    for (int n = 0; n < 40000; n++) begin
      xfer(1'b0, OFS_STATUS, '0);
      if (rd[b] === v) break;
    end
    chk("status bit", {31'h0, rd[b]}, {31'h0, v});
  endtask
  task automatic rst(input logic [1:0] spd, m, input logic [7:0] cmd, exp,
                     input logic [15:0] lt);
    mode <= m;
    xfer(1'b1, OFS_SPEED, {30'h0, spd});
    xfer(1'b1, OFS_CMD, {24'h0, cmd});
    waitSt(2, 1'b1);
    xfer(1'b0, OFS_RESULT, '0);
    chk("reset result", rd, {24'h0, exp});
    chk("reset low", near(lowLen, 32'(lt) * 40), 32'(lt) * 40);
  endtask
  task automatic slot(input logic [7:0] cmd, input logic rz,
                      input logic [31:0] exp, us);
    readZero <= rz;
    xfer(1'b1, OFS_CMD, {24'h0, cmd});
    waitSt(2, 1'b1);
    xfer(1'b0, OFS_RESULT, '0);
    if (cmd[2]) chk("slot result", rd, exp);
    chk("slot low", near(lowLen, us * 40), us * 40);
  endtask

  always @(posedge mclk) begin
    oePrev <= busOe;
    weakPrev <= weakPuEn;
    if (busOe && !oePrev) chk("weak off", {31'h0, weakPrev}, '0);
    if (mode == 2'h0 && pullLow) chk("weak on", {31'h0, weakPuEn}, 1);
    lowCnt <= busOe ? lowCnt + 1 : '0;
    if (!busOe && oePrev) lowLen <= lowCnt;
    spuCnt <= strongPuEn ? spuCnt + 1 : '0;
    if (!strongPuEn && spuCnt != 0) spuLen <= spuCnt;
  end

  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    xfer(1'b0, OFS_SPEED, '0);
    chk("speed", rd, 32'h0);
    xfer(1'b0, OFS_LOW1, '0);
    chk("low1", rd, 32'h8);
    xfer(1'b0, OFS_DSO, '0);
    chk("dso", rd, 32'h7);
    xfer(1'b0, OFS_REC0, '0);
    chk("rec0", rd, 32'h12);
    xfer(1'b0, OFS_SPU, '0);
    chk("spu", rd, 32'h200);
    xfer(1'b0, 8'h30, '0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, '0);
    chk("drive level", {31'h0, busOut}, '0);
    $display("test registers done");
    xfer(1'b1, OFS_LOW1, 32'h5);
    xfer(1'b1, OFS_DSO, 32'h7);
    rst(2'h1, 2'h1, 8'h18, 8'h12, 16'h0200);
    rst(2'h2, 2'h0, 8'h10, 8'h10, 16'h0040);
    rst(2'h2, 2'h2, 8'h10, 8'h11, 16'h0040);
    rst(2'h2, 2'h3, 8'h10, 8'h14, 16'h0040);
    $display("test reset done");
    mode <= 2'h1;
    xfer(1'b1, OFS_SPEED, 32'h1);
    slot(8'h05, 1'b0, 32'h08, 32'd5);
    slot(8'h05, 1'b1, 32'h00, 32'd5);
    slot(8'h01, 1'b0, 32'h00, 32'd60);
    $display("test slots done");
    xfer(1'b1, OFS_SPU, 32'ha);
    xfer(1'b1, OFS_CMD, 32'h22);
    waitSt(3, 1'b1);
    waitSt(1, 1'b0);
    chk("pulse len", near(spuLen, 32'd400), 32'd400);
    xfer(1'b1, OFS_SPU, 32'h0);
    xfer(1'b1, OFS_CMD, 32'h22);
    repeat (200) @(posedge mclk);
    #1 chk("pulse held", {31'h0, strongPuEn}, 1);
    @(posedge mclk);
    xfer(1'b1, OFS_HALT, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk("pulse ended", {31'h0, strongPuEn}, 0);
    @(posedge mclk);
    waitSt(1, 1'b0);
    $display("test pulse done");
    xfer(1'b1, OFS_SPEED, 32'h2);
    repeat (6) xfer(1'b1, OFS_CMD, 32'h25);
    xfer(1'b0, OFS_STATUS, '0);
    chk("fifo full", {31'h0, rd[4]}, 1);
    waitSt(3, 1'b1);
    waitSt(1, 1'b0);
    xfer(1'b0, OFS_CMD, '0);
    chk("last cmd", rd, 32'h25);
    $display("test fifo done");
    close_out();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
